// >>> hw/plrdc_top.sv
// Contract
// - Each synthesiser multiplies its input clock by integer part plus fraction over 2^22.
// - Bit 0 of each divider register passes the oscillator clock whole or halved.
// - In user mode code 00..11 divides by 2,4,8,12, or 4,8,16,24 with post-scale set.
// - In receiver mode the first post-scale bit picks 256fs (0) or 128fs (1).
// - In receiver mode the first code comes from the receiver; second code and post-scale are ignored.
// - After reset pre-scale is 0, post-scale 0 and code 10, a divide by eight.
// - The fraction spans three registers, top nibble beside the integer multiplier.
// - User mode while the receiver is off, receiver mode while it is on.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

`include "plrdc_consts.svh"

module plrdc_top
  import plrdc_pkg::*;
(
  // Clock and reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_srst,
  // Register port
  input  wire logic [`PLRDC_ADDR_W-1:0]   i_addr,
  input  wire logic [`PLRDC_DATA_W-1:0]   i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [`PLRDC_DATA_W-1:0]   o_rdata,
  // Receiver side
  input  wire logic                       i_rx_enable,
  input  wire logic [`PLRDC_INT_W-1:0]    i_rx_a_int_mult,
  input  wire logic [`PLRDC_FRAC_W-1:0]   i_rx_a_frac_mult,
  input  wire logic [1:0]                 i_rx_a_out_div_code,
  // Synthesiser loop side
  input  wire logic                       i_synth_a_f2_tick,
  input  wire logic                       i_synth_b_f2_tick,
  output logic      [`PLRDC_RATIO_W-1:0]  o_synth_a_ratio,
  output logic      [`PLRDC_RATIO_W-1:0]  o_synth_b_ratio,
  output logic                            o_synth_a_ref_tick,
  output logic                            o_synth_b_ref_tick,
  output logic                            o_synth_a_output_clock,
  output logic                            o_synth_b_output_clock,
  output logic                            o_rx_mode
);

  typedef struct packed {
    logic [`PLRDC_INT_W-1:0]  n;
    logic [`PLRDC_FRAC_W-1:0] k;
    plrdc_div_cfg_s           div;
  } plrdc_synth_s;

  typedef struct packed {
    plrdc_synth_s                a;
    plrdc_synth_s                b;
    plrdc_mode_e                 mode;
    logic [`PLRDC_RATIO_W-1:0]   ratio_a;
    logic [`PLRDC_RATIO_W-1:0]   ratio_b;
    plrdc_div_cfg_s              eff_a;
    plrdc_div_cfg_s              eff_b;
    logic [`PLRDC_DATA_W-1:0]    rdata;
  } plrdc_state_s;

  localparam plrdc_synth_s SYNTH_RST = '{
    n:   `PLRDC_RST_N,
    k:   {`PLRDC_RST_KHI, `PLRDC_RST_KMID, `PLRDC_RST_KLO},
    div: '{halve: `PLRDC_RST_HALVE, double_div: `PLRDC_RST_DOUBLE, code: `PLRDC_RST_CODE}
  };

  plrdc_state_s st_q;
  plrdc_state_s st_d;

  plrdc_div_if a_if ();
  plrdc_div_if b_if ();

  function automatic plrdc_div_cfg_s cfg_of(input logic [`PLRDC_DATA_W-1:0] w);
    plrdc_div_cfg_s c;
    c.halve      = w[`PLRDC_DIV_HALVE_BIT];
    c.double_div = w[`PLRDC_DIV_DOUBLE_BIT];
    c.code       = w[`PLRDC_DIV_CODE_MSB:`PLRDC_DIV_CODE_LSB];
    return c;
  endfunction

  function automatic logic [`PLRDC_DATA_W-1:0] word_of(input plrdc_div_cfg_s c);
    logic [`PLRDC_DATA_W-1:0] w;
    w = '0;
    w[`PLRDC_DIV_HALVE_BIT]  = c.halve;
    w[`PLRDC_DIV_DOUBLE_BIT] = c.double_div;
    w[`PLRDC_DIV_CODE_MSB:`PLRDC_DIV_CODE_LSB] = c.code;
    return w;
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;

    // Register writes
    if (i_wr) begin
      case (i_addr)
        `PLRDC_REG_A_KLO:  st_d.a.k[8:0]   = i_wdata;
        `PLRDC_REG_A_KMID: st_d.a.k[17:9]  = i_wdata;
        `PLRDC_REG_A_NKHI: begin
          st_d.a.k[21:18] = i_wdata[3:0];
          st_d.a.n        = i_wdata[7:4];
        end
        `PLRDC_REG_A_DIV:  st_d.a.div      = cfg_of(i_wdata);
        `PLRDC_REG_B_KLO:  st_d.b.k[8:0]   = i_wdata;
        `PLRDC_REG_B_KMID: st_d.b.k[17:9]  = i_wdata;
        `PLRDC_REG_B_NKHI: begin
          st_d.b.k[21:18] = i_wdata[3:0];
          st_d.b.n        = i_wdata[7:4];
        end
        `PLRDC_REG_B_DIV:  st_d.b.div      = cfg_of(i_wdata);
        default: ;
      endcase
    end

    // Register reads, data in the following cycle
    if (i_rd) begin
      case (i_addr)
        `PLRDC_REG_A_KLO:  st_d.rdata = st_q.a.k[8:0];
        `PLRDC_REG_A_KMID: st_d.rdata = st_q.a.k[17:9];
        `PLRDC_REG_A_NKHI: st_d.rdata = {1'b0, st_q.a.n, st_q.a.k[21:18]};
        `PLRDC_REG_A_DIV:  st_d.rdata = word_of(st_q.a.div);
        `PLRDC_REG_B_KLO:  st_d.rdata = st_q.b.k[8:0];
        `PLRDC_REG_B_KMID: st_d.rdata = st_q.b.k[17:9];
        `PLRDC_REG_B_NKHI: st_d.rdata = {1'b0, st_q.b.n, st_q.b.k[21:18]};
        `PLRDC_REG_B_DIV:  st_d.rdata = word_of(st_q.b.div);
        `PLRDC_REG_STATUS: st_d.rdata = {st_q.eff_b.code, st_q.eff_b.double_div,
                                         st_q.eff_a.code, st_q.eff_a.double_div,
                                         2'h0, st_q.mode};
        default:           st_d.rdata = '0;
      endcase
    end

    // Mode follows the receiver enable
    st_d.mode = i_rx_enable ? PLRDC_MODE_RX : PLRDC_MODE_USER;

    // Effective settings of the first synthesiser
    st_d.eff_a = st_q.a.div;
    if (st_q.mode == PLRDC_MODE_RX) begin
      st_d.eff_a.code = i_rx_a_out_div_code;
      // Post-scale 0 doubles the output: 256fs, else 128fs
      st_d.eff_a.double_div = st_q.a.div.double_div;
      st_d.ratio_a = {i_rx_a_int_mult, i_rx_a_frac_mult};
    end else begin
      st_d.ratio_a = {st_q.a.n, st_q.a.k};
    end

    // Second synthesiser: output divider settings ignored in receiver mode
    st_d.eff_b = st_q.b.div;
    if (st_q.mode == PLRDC_MODE_RX) begin
      st_d.eff_b.code       = `PLRDC_RST_CODE;
      st_d.eff_b.double_div = `PLRDC_RST_DOUBLE;
    end
    st_d.ratio_b = {st_q.b.n, st_q.b.k};
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q.a       <= SYNTH_RST;
      st_q.b       <= SYNTH_RST;
      st_q.mode    <= PLRDC_MODE_USER;
      st_q.ratio_a <= {`PLRDC_RST_N, `PLRDC_RST_KHI, `PLRDC_RST_KMID, `PLRDC_RST_KLO};
      st_q.ratio_b <= {`PLRDC_RST_N, `PLRDC_RST_KHI, `PLRDC_RST_KMID, `PLRDC_RST_KLO};
      st_q.eff_a   <= SYNTH_RST.div;
      st_q.eff_b   <= SYNTH_RST.div;
      st_q.rdata   <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Divider links
  assign a_if.cfg     = st_q.eff_a;
  assign b_if.cfg     = st_q.eff_b;
  assign a_if.f2_tick = i_synth_a_f2_tick;
  assign b_if.f2_tick = i_synth_b_f2_tick;

  plrdc_prescale u_pre_a (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .div        (a_if.pre)
  );

  plrdc_prescale u_pre_b (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .div        (b_if.pre)
  );

  plrdc_out_div u_post_a (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .div        (a_if.post)
  );

  plrdc_out_div u_post_b (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .div        (b_if.post)
  );

  // Outputs
  assign o_rdata                = st_q.rdata;
  assign o_synth_a_ratio        = st_q.ratio_a;
  assign o_synth_b_ratio        = st_q.ratio_b;
  assign o_synth_a_ref_tick     = a_if.ref_tick;
  assign o_synth_b_ref_tick     = b_if.ref_tick;
  assign o_synth_a_output_clock = a_if.out_clk;
  assign o_synth_b_output_clock = b_if.out_clk;
  assign o_rx_mode              = st_q.mode;

endmodule

`default_nettype wire

// >>> hw/plrdc_consts.svh
`ifndef PLRDC_CONSTS_SVH
`define PLRDC_CONSTS_SVH

// Register indices (byte address equals index on the plain port)
`define PLRDC_ADDR_W          4
`define PLRDC_DATA_W          9
`define PLRDC_REG_A_KLO       4'h0
`define PLRDC_REG_A_KMID      4'h1
`define PLRDC_REG_A_NKHI      4'h2
`define PLRDC_REG_A_DIV       4'h3
`define PLRDC_REG_B_KLO       4'h4
`define PLRDC_REG_B_KMID      4'h5
`define PLRDC_REG_B_NKHI      4'h6
`define PLRDC_REG_B_DIV       4'h7
`define PLRDC_REG_STATUS      4'h8

// Field positions of the divider registers
`define PLRDC_DIV_HALVE_BIT   0
`define PLRDC_DIV_DOUBLE_BIT  1
`define PLRDC_DIV_CODE_LSB    3
`define PLRDC_DIV_CODE_MSB    4

// Multiplier layout
`define PLRDC_FRAC_W          22
`define PLRDC_INT_W           4
`define PLRDC_RATIO_W         26

// Reset values
`define PLRDC_RST_KLO         9'h121
`define PLRDC_RST_KMID        9'h17e
`define PLRDC_RST_KHI         4'hd
`define PLRDC_RST_N           4'h7
`define PLRDC_RST_HALVE       1'b0
`define PLRDC_RST_DOUBLE      1'b0
`define PLRDC_RST_CODE        2'h2

// Half output periods in f2 ticks for codes 00..11 (divide by 2,4,8,12)
`define PLRDC_HALF_CODE0      5'h01
`define PLRDC_HALF_CODE1      5'h02
`define PLRDC_HALF_CODE2      5'h04
`define PLRDC_HALF_CODE3      5'h06

`endif

// >>> hw/plrdc_pkg.sv
`include "plrdc_consts.svh"

package plrdc_pkg;

  typedef enum logic [0:0] {
    PLRDC_MODE_USER = 1'b0,
    PLRDC_MODE_RX   = 1'b1
  } plrdc_mode_e;

  typedef logic [4:0] plrdc_half_t;

  // Divider settings for one synthesiser
  typedef struct packed {
    logic       halve;
    logic       double_div;
    logic [1:0] code;
  } plrdc_div_cfg_s;

  function automatic plrdc_half_t plrdc_half_of(input plrdc_div_cfg_s cfg);
    plrdc_half_t h;
    h = `PLRDC_HALF_CODE0;
    case (cfg.code)
      2'h0:    h = `PLRDC_HALF_CODE0;
      2'h1:    h = `PLRDC_HALF_CODE1;
      2'h2:    h = `PLRDC_HALF_CODE2;
      default: h = `PLRDC_HALF_CODE3;
    endcase
    if (cfg.double_div) begin
      h = {h[3:0], 1'b0};
    end
    return h;
  endfunction

endpackage

// >>> hw/plrdc_div_if.sv
`timescale 1ns/10ps
`default_nettype none

interface plrdc_div_if;
  import plrdc_pkg::*;
  plrdc_div_cfg_s cfg;
  logic           ref_tick;
  logic           f2_tick;
  logic           out_clk;

  modport ctrl (output cfg, input ref_tick, output f2_tick, input out_clk);
  modport pre  (input cfg, output ref_tick);
  modport post (input cfg, input f2_tick, output out_clk);
endinterface

`default_nettype wire

// >>> hw/plrdc_prescale.sv
`timescale 1ns/10ps
`default_nettype none

module plrdc_prescale
  import plrdc_pkg::*;
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  // Settings and reference tick
  plrdc_div_if.pre  div
);

  typedef struct packed {
    logic halve;
    logic phase;
  } plrdc_pre_s;

  plrdc_pre_s st_q;
  plrdc_pre_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.phase = ~st_q.phase;
    // Setting taken only at a whole input period boundary
    if (!st_q.halve || st_q.phase) begin
      st_d.halve = div.cfg.halve;
      st_d.phase = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '{halve: `PLRDC_RST_HALVE, phase: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // One tick per oscillator cycle, or every second one when halved
  assign div.ref_tick = !st_q.halve || st_q.phase;

endmodule

`default_nettype wire

// >>> hw/plrdc_out_div.sv
`timescale 1ns/10ps
`default_nettype none

module plrdc_out_div
  import plrdc_pkg::*;
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  // Settings, f2 ticks, divided clock
  plrdc_div_if.post div
);

  typedef struct packed {
    plrdc_half_t half;
    plrdc_half_t cnt;
    logic        lvl;
  } plrdc_post_s;

  plrdc_post_s st_q;
  plrdc_post_s st_d;

  always_comb begin
    st_d = st_q;
    if (div.f2_tick) begin
      if (st_q.cnt == st_q.half - 5'h01) begin
        st_d.cnt = '0;
        st_d.lvl = ~st_q.lvl;
        // New factor only at the end of a full low phase
        if (!st_q.lvl) begin
          st_d.half = plrdc_half_of(div.cfg);
        end
      end else begin
        st_d.cnt = st_q.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= '{half: `PLRDC_HALF_CODE2, cnt: '0, lvl: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign div.out_clk = st_q.lvl;

endmodule

`default_nettype wire

// >>> tb/plrdc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "plrdc_consts.svh"
module plrdc_monitor (
  // Clock, reset, register port
  input wire logic                      i_core_clk,
  input wire logic                      i_srst,
  input wire logic [`PLRDC_ADDR_W-1:0]  i_addr,
  input wire logic [`PLRDC_DATA_W-1:0]  i_wdata,
  input wire logic                      i_wr,
  input wire logic                      i_rd,
  input wire logic [`PLRDC_DATA_W-1:0]  o_rdata,
  // Receiver and loop side
  input wire logic                      i_rx_enable,
  input wire logic [`PLRDC_INT_W-1:0]   i_rx_a_int_mult,
  input wire logic [`PLRDC_FRAC_W-1:0]  i_rx_a_frac_mult,
  input wire logic                      i_synth_a_f2_tick,
  input wire logic                      i_synth_b_f2_tick,
  input wire logic [`PLRDC_RATIO_W-1:0] o_synth_a_ratio,
  input wire logic [`PLRDC_RATIO_W-1:0] o_synth_b_ratio,
  input wire logic                      o_synth_a_ref_tick,
  input wire logic                      o_synth_a_output_clock,
  input wire logic                      o_synth_b_output_clock,
  input wire logic                      o_rx_mode
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 9'h000)
    else $error("read data not idle");
  chk_div_readback: assert property ((i_wr && i_addr == 4'h3)
    ##1 (i_rd && i_addr == 4'h3) |=> o_rdata == ($past(i_wdata, 2) & 9'h01b))
    else $error("divider readback wrong");
  chk_unmapped_read: assert property (i_rd && i_addr > 4'h8 |=> o_rdata == 9'h000)
    else $error("unmapped read not zero");
  chk_reset_ratio: assert property ($past(i_srst) |-> o_synth_a_ratio == 26'h1f6fd21
    && o_synth_b_ratio == 26'h1f6fd21) else $error("ratio reset wrong");
  chk_ref_tick_gap: assert property (!o_synth_a_ref_tick |=> o_synth_a_ref_tick)
    else $error("ref tick gap too long");
  chk_rx_mode_lag: assert property (!$past(i_srst) |-> o_rx_mode == $past(i_rx_enable))
    else $error("mode lag wrong");
  chk_rx_a_ratio: assert property ((o_rx_mode && $stable(i_rx_a_int_mult)
    && $stable(i_rx_a_frac_mult))[*3] |-> o_synth_a_ratio == {i_rx_a_int_mult, i_rx_a_frac_mult})
    else $error("receiver ratio not used");
  chk_a_clk_tick: assert property ($changed(o_synth_a_output_clock) |-> $past(i_synth_a_f2_tick))
    else $error("clock A moved without tick");
  chk_b_clk_tick: assert property ($changed(o_synth_b_output_clock) |-> $past(i_synth_b_f2_tick))
    else $error("clock B moved without tick");
  chk_rx_status: assert property ((o_rx_mode[*3] ##0 (i_rd && i_addr == 4'h8))
    |=> o_rdata[8:6] == 3'b100 && o_rdata[0]) else $error("status in receiver mode wrong");
  cov_rx: cover property ($rose(o_rx_mode));
  cov_readback: cover property ((i_wr && i_addr == 4'h3) ##1 i_rd);
  cov_halved: cover property (!o_synth_a_ref_tick);
endmodule
bind plrdc_top plrdc_monitor u_mon (.*);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "plrdc_consts.svh"
module tb_top;
  logic        i_core_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [3:0]  i_addr = 4'h0;
  logic [8:0]  i_wdata = 9'h000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [8:0]  o_rdata;
  logic        i_rx_enable = 1'b0;
  logic [3:0]  rx_n = 4'h0;
  logic [21:0] rx_k = 22'h000000;
  logic [1:0]  rx_code = 2'h0;
  logic        f2a = 1'b1;
  logic        f2b = 1'b1;
  logic [25:0] rat_a;
  logic [25:0] rat_b;
  logic        ref_a;
  logic        ref_b;
  logic        clk_a;
  logic        clk_b;
  logic        rx_mode;
  int          error_cnt = 0;
  int          cmp_count = 0;
  logic [8:0]  d;
  int          n;
  int          m;
  always #50 i_core_clk = ~i_core_clk;
  plrdc_top DUT (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_enable(i_rx_enable),
    .i_rx_a_int_mult(rx_n), .i_rx_a_frac_mult(rx_k), .i_rx_a_out_div_code(rx_code),
    .i_synth_a_f2_tick(f2a), .i_synth_b_f2_tick(f2b), .o_synth_a_ratio(rat_a),
    .o_synth_b_ratio(rat_b), .o_synth_a_ref_tick(ref_a), .o_synth_b_ref_tick(ref_b),
    .o_synth_a_output_clock(clk_a), .o_synth_b_output_clock(clk_b), .o_rx_mode(rx_mode));
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [8:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [8:0] v);
    @(posedge i_core_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // Write then read the same divider register with no gap
  task automatic wr_rd(input logic [3:0] a, input logic [8:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0; i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(26'(o_rdata), 26'(v & 9'h01b));
  endtask
  // High time of an output clock from its second rising edge
  task automatic meas(input bit b, output int hi);
    int r;
    logic p;
    logic c;
    r = 0;
    hi = 0;
    #1 p = b ? clk_b : clk_a;
    for (int i = 0; i < 400 && r < 2; i++) begin
      @(posedge i_core_clk);
      #1 c = b ? clk_b : clk_a;
      if (!p && c) r++;
      p = c;
    end
    if (r < 2) begin
      error_cnt++;
      test_done();
    end
    for (int i = 0; i < 100 && p; i++) begin
      hi++;
      @(posedge i_core_clk);
      #1 p = b ? clk_b : clk_a;
    end
  endtask
  logic [3:0] ra[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'h9};
  logic [8:0] rv[7] = '{9'h121, 9'h17e, 9'h07d, 9'h010, 9'h010, 9'h120, 9'h000};
  int         fac[4] = '{2, 4, 8, 12};
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_srst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], d);
      chk(26'(d), 26'(rv[i]));
    end
    meas(1'b0, n);
    chk(26'(n), 26'd4);
    // Output clock holds while the loop gives no ticks
    @(posedge i_core_clk);
    f2a <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1 n = int'(clk_a);
    repeat (20) @(posedge i_core_clk);
    #1 chk(26'(clk_a), 26'(n));
    @(posedge i_core_clk);
    f2a <= 1'b1;
    wr(4'h0, 9'h1ba);
    wr(4'h1, 9'h024);
    wr(4'h2, 9'h083);
    repeat (2) @(posedge i_core_clk);
    #1 chk(rat_a, 26'h20c49ba);
    chk(rat_b, 26'h1f6fd21);
    wr_rd(4'h3, 9'h1ff);
    repeat (3) @(posedge i_core_clk);
    n = 0;
    m = 0;
    for (int i = 0; i < 4; i++) begin
      @(posedge i_core_clk);
      #1 n += int'(ref_a);
      m += int'(ref_b);
    end
    chk(26'(n), 26'd2);
    chk(26'(m), 26'd4);
    wr(4'hf, 9'h1ff);
    rd(4'hf, d);
    chk(26'(d), 26'h0);
    for (int c = 0; c < 8; c++) begin
      wr(4'h7, 9'((c % 4) * 8 + (c / 4) * 2));
      meas(1'b1, n);
      chk(26'(n), 26'((fac[c % 4] << (c / 4)) / 2));
    end
    wr(4'h3, 9'h002);
    @(posedge i_core_clk);
    rx_n <= 4'h9; rx_k <= 22'h2aaaaa; rx_code <= 2'h3; i_rx_enable <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    #1 chk(rat_a, 26'h26aaaaa);
    rd(4'h8, d);
    chk(26'(d), 26'h139);
    meas(1'b0, n);
    chk(26'(n), 26'd12);
    meas(1'b1, n);
    chk(26'(n), 26'd4);
    @(posedge i_core_clk);
    i_rx_enable <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    #1 chk(rat_a, 26'h20c49ba);
    test_done();
  end
endmodule
`default_nettype wire
